// *** src/uqs_pkg.sv ***
// Constants, carrier structs and helpers for the queue/status engine.
// Assumes a 32-bit memory port and a 32-bit Wishbone register bus.
package uqs_pkg;

    // Register byte offsets
    localparam logic [7:0] UQS_CMD_OFS = 8'h00;
    localparam logic [7:0] UQS_STS_OFS = 8'h04;

    // Command register bit positions
    localparam int CMD_RUN = 0;
    localparam int CMD_HCRST = 1;
    localparam int CMD_GRST = 2;
    localparam int CMD_SUSP = 3;
    localparam int CMD_CFG = 6;

    // Link pointer layout
    localparam int LNK_T = 0;
    localparam int LNK_Q = 1;
    localparam int LNK_VF = 2;
    localparam logic [31:0] LNK_ADDR_MASK = 32'hFFFF_FFF0;

    // Byte offsets of words inside structures
    localparam logic [31:0] QH_HLINK_OFS = 32'h0000_0000;
    localparam logic [31:0] QH_VLINK_OFS = 32'h0000_0004;
    localparam logic [31:0] TD_STS_OFS = 32'h0000_0004;

    // Descriptor status word layout
    localparam int TDS_CRCTO = 18;
    localparam int TDS_STALL = 22;
    localparam int TDS_ACT = 23;
    localparam int TDS_IOC = 24;
    localparam int TDS_CNT_LO = 27;

    // Walker states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_FETCH = 7'h02,
        ST_QHV = 7'h04,
        ST_EXEC = 7'h08,
        ST_WBS = 7'h10,
        ST_WBQ = 7'h20,
        ST_DONE = 7'h40
    } uqs_state_type;

    // Status flags, packed so bit n is status register bit n
    typedef struct packed {
        logic halted;
        logic proc_err;
        logic sys_err;
        logic resume;
        logic err_irq;
        logic done_irq;
    } uqs_sts_type;

    typedef struct packed {
        logic [31:0] status;
        logic ok;
        logic null_pkt;
        logic nak;
        logic crc_to;
        logic stuff_err;
        logic buf_err;
        logic setup_hs;
        logic pid_err;
        logic len_err;
    } uqs_result_type;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } uqs_mem_req_type;

    typedef struct packed {
        logic ack;
        logic abort;
        logic [31:0] rdata;
    } uqs_mem_rsp_type;

    typedef struct packed {
        logic wr_cmd;
        logic wr_sts;
        logic [31:0] wdata;
    } uqs_regwr_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } uqs_wbs_type;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] hlink;
        logic [31:0] vlink;
    } uqs_qhc_type;

    typedef struct packed {
        uqs_state_type st;
        logic run;
        logic cfg;
        logic susp;
        uqs_sts_type sts;
        logic qctx;
        logic cur_qh;
        logic adv;
        logic pend;
        logic exec_req;
        logic [31:0] fptr;
        logic [31:0] ptr;
        logic [31:0] hlink;
        logic [31:0] td_addr;
        logic [31:0] td_link;
        uqs_mem_req_type mem;
    } uqs_eng_type;

    function automatic logic [31:0] uqs_link_addr(input logic [31:0] lp);
        return lp & LNK_ADDR_MASK;
    endfunction

    function automatic logic uqs_res_err(input uqs_result_type r);
        return r.crc_to | r.stuff_err | r.buf_err | r.setup_hs;
    endfunction

    // Error count, stall and active bits for the status write-back
    function automatic logic [31:0] uqs_td_update(input uqs_result_type r);
        logic [31:0] s;
        logic [1:0] c;
        logic e;
        s = r.status;
        c = s[TDS_CNT_LO +: 2];
        e = uqs_res_err(r);
        if (e && c != 2'h0) begin
            s[TDS_CNT_LO +: 2] = c - 2'h1;
        end
        if (e && c == 2'h1) begin
            s[TDS_ACT] = 1'b0;
            s[TDS_STALL] = 1'b1;
        end
        if (r.setup_hs) begin
            s[TDS_CRCTO] = 1'b1;
        end
        if ((r.ok || r.null_pkt) && !e) begin
            s[TDS_ACT] = 1'b0;
        end
        return s;
    endfunction

endpackage

// *** src/uqs_qh_cache.sv ***
// Cached copy of the queue header currently being worked.
// Assumes clear and load are never meant to act together; clear wins.
`timescale 1ns/1ns
module uqs_qh_cache import uqs_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control and data in
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] hlink_i,
    input wire logic [31:0] vlink_i,
    // Stored header
    output logic valid_o,
    output logic [31:0] addr_o,
    output logic [31:0] hlink_o,
    output logic [31:0] vlink_o
);

    uqs_qhc_type q;
    uqs_qhc_type d;

    always_comb begin
        d = q;
        if (clear_i) begin
            d = '0;
        end else if (load_i) begin
            d.valid = 1'b1;
            d.addr = addr_i;
            d.hlink = hlink_i;
            d.vlink = vlink_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign valid_o = q.valid;
    assign addr_o = q.addr;
    assign hlink_o = q.hlink;
    assign vlink_o = q.vlink;

endmodule

// *** src/uqs_queue_engine.sv ***
// Queue walker and command/status flag logic of a USB host controller.
// Assumes an execution unit that runs one descriptor per request and a
// memory port with a req/ack handshake and an abort indication.
// Behaviour
// - Counted-out error clears active, sets stall and error flag.
// - Bad packet id or length stops run, sets process error and halted.
// - Bus abort stops run, sets system bus error and halted.
// - Suspend only entered while stopped; stopped controller shows halted.
// - Resume seen during suspend sets the resume flag.
// - Software setting the configured bit is recorded in the command word.
// - Controller or global reset clears every command and status flag.
// - Completed descriptor with completion interrupt bit sets completion flag.
// - NAK or STALL to SETUP counts as time-out in the write-back.
// - Queue header is two words: horizontal link then vertical link.
// - Terminated horizontal link ends work for the frame.
// - Terminated vertical link means an empty queue, nothing executed.
// - Vertical link to a header enters new context, old one untouched.
// - Met headers are cached and queue context is recorded.
// - On advance, descriptor link is written into the header's vertical link.
// - Breadth-first: element, write-back, then horizontal link.
// - Failed advance leaves queue as is and takes the horizontal link.
// - Depth-first advance follows the descriptor's own link next.
// - Queue advances only on good or null transfer, never on error or NAK.
// - Link bit one selects header versus descriptor, bit zero terminates.
// - Link bits 31:4 are the address; structures are 16-byte aligned.
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
module uqs_queue_engine import uqs_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Frame timing
    input wire logic frame_start_i,
    input wire logic [31:0] frame_ptr_i,
    input wire logic resume_i,
    // Memory port
    output uqs_mem_req_type mem_o,
    input wire uqs_mem_rsp_type mem_i,
    // Descriptor execution
    output logic exec_req_o,
    output logic [31:0] exec_td_o,
    input wire logic exec_done_i,
    input wire uqs_result_type exec_res_i,
    // State
    output logic walk_idle_o,
    output logic run_o,
    output logic halted_o
);

    uqs_eng_type q;
    uqs_eng_type d;
    uqs_regwr_type regwr;
    logic [31:0] cmd_rd;
    logic [31:0] sts_rd;
    logic hc_rst;
    logic ackd;
    logic go;
    logic go_q;
    logic [31:0] go_ptr;
    logic cache_clr;
    logic cache_ld;
    logic qh_v;
    logic [31:0] qh_a;
    logic [31:0] qh_h;
    logic [31:0] qh_vl;
    logic res_err;
    logic res_good;
    logic res_bad;
    logic [1:0] res_cnt;
    logic done_ev;

    uqs_wb_slave u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .cmd_rd_i(cmd_rd),
        .sts_rd_i(sts_rd),
        .regwr_o(regwr)
    );

    uqs_qh_cache u_cache (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(cache_clr),
        .load_i(cache_ld),
        .addr_i(uqs_link_addr(q.ptr)),
        .hlink_i(q.hlink),
        .vlink_i(mem_i.rdata),
        .valid_o(qh_v),
        .addr_o(qh_a),
        .hlink_o(qh_h),
        .vlink_o(qh_vl)
    );

    always_comb begin
        cmd_rd = 32'h0000_0000;
        cmd_rd[CMD_RUN] = q.run;
        cmd_rd[CMD_SUSP] = q.susp;
        cmd_rd[CMD_CFG] = q.cfg;
        sts_rd = {26'h000_0000, q.sts};
    end

    assign hc_rst = regwr.wr_cmd && (regwr.wdata[CMD_HCRST] || regwr.wdata[CMD_GRST]);
    assign ackd = q.mem.req && mem_i.ack;
    assign res_err = uqs_res_err(exec_res_i);
    assign res_good = (exec_res_i.ok || exec_res_i.null_pkt) && !res_err;
    assign res_bad = exec_res_i.pid_err || exec_res_i.len_err;
    assign res_cnt = exec_res_i.status[TDS_CNT_LO +: 2];
    assign done_ev = (q.st == ST_EXEC) && exec_done_i;

    always_comb begin
        d = q;
        go = 1'b0;
        go_q = 1'b0;
        go_ptr = q.ptr;
        cache_clr = 1'b0;
        cache_ld = 1'b0;
        // A frame start during a walk waits until the walk settles
        if (frame_start_i) begin
            d.pend = 1'b1;
            d.fptr = frame_ptr_i;
        end
        if (regwr.wr_cmd) begin
            // suspend gated by a stopped controller
            d.susp = regwr.wdata[CMD_SUSP] && !q.run && !regwr.wdata[CMD_RUN];
            d.run = regwr.wdata[CMD_RUN] && !d.susp;
            d.cfg = regwr.wdata[CMD_CFG];
            if (d.run && !q.run) begin
                d.sts.halted = 1'b0;
            end
        end
        // Write one to clear; hardware sets below take priority
        if (regwr.wr_sts) begin
            d.sts = d.sts & ~uqs_sts_type'(regwr.wdata[5:0]);
        end
        if (!q.run) begin
            d.sts.halted = 1'b1;
        end
        if (resume_i && q.susp) begin
            d.sts.resume = 1'b1;
        end
        if (q.mem.req && mem_i.abort) begin
            d.mem.req = 1'b0;
            d.run = 1'b0;
            d.sts.sys_err = 1'b1;
            d.sts.halted = 1'b1;
            d.st = ST_IDLE;
        end else begin
            case (q.st)
                ST_IDLE, ST_DONE: begin
                    if (q.pend) begin
                        d.pend = frame_start_i;
                        if (q.run) begin
                            cache_clr = 1'b1;
                            go = 1'b1;
                            go_ptr = q.fptr;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                ST_FETCH: begin
                    if (ackd) begin
                        d.mem.req = 1'b0;
                        if (q.cur_qh) begin
                            // second header word is the vertical link
                            d.hlink = mem_i.rdata;
                            d.mem.req = 1'b1;
                            d.mem.addr = uqs_link_addr(q.ptr) + QH_VLINK_OFS;
                            d.st = ST_QHV;
                        end else begin
                            d.td_link = mem_i.rdata;
                            d.td_addr = uqs_link_addr(q.ptr);
                            d.exec_req = 1'b1;
                            d.st = ST_EXEC;
                        end
                    end
                end
                ST_QHV: begin
                    if (ackd) begin
                        d.mem.req = 1'b0;
                        cache_ld = 1'b1;
                        go = 1'b1;
                        go_q = 1'b1;
                        // empty queue skips to horizontal link
                        if (mem_i.rdata[LNK_T]) begin
                            go_ptr = q.hlink;
                            go_q = 1'b0;
                        end else begin
                            // header below header reloads the cache
                            go_ptr = mem_i.rdata;
                        end
                    end
                end
                ST_EXEC: begin
                    if (exec_done_i) begin
                        d.exec_req = 1'b0;
                        if (res_bad) begin
                            d.run = 1'b0;
                            d.sts.proc_err = 1'b1;
                            d.sts.halted = 1'b1;
                            d.st = ST_IDLE;
                        end else begin
                            d.mem.req = 1'b1;
                            d.mem.we = 1'b1;
                            d.mem.addr = q.td_addr + TD_STS_OFS;
                            d.mem.wdata = uqs_td_update(exec_res_i);
                            // advance only on good or null transfer
                            d.adv = res_good;
                            // error flag on counter 1 to 0
                            if (res_err && res_cnt == 2'h1) begin
                                d.sts.err_irq = 1'b1;
                            end
                            if (res_good && exec_res_i.status[TDS_IOC]) begin
                                d.sts.done_irq = 1'b1;
                            end
                            d.st = ST_WBS;
                        end
                    end
                end
                ST_WBS: begin
                    if (ackd) begin
                        d.mem.req = 1'b0;
                        if (q.qctx && q.adv) begin
                            d.mem.req = 1'b1;
                            d.mem.we = 1'b1;
                            d.mem.addr = qh_a + QH_VLINK_OFS;
                            d.mem.wdata = q.td_link;
                            d.st = ST_WBQ;
                        end else begin
                            go = 1'b1;
                            go_ptr = q.qctx ? qh_h : q.td_link;
                        end
                    end
                end
                ST_WBQ: begin
                    if (ackd) begin
                        d.mem.req = 1'b0;
                        go = 1'b1;
                        if (q.td_link[LNK_VF]) begin
                            go_ptr = q.td_link;
                            go_q = 1'b1;
                        end else begin
                            go_ptr = qh_h;
                        end
                    end
                end
                default: begin
                    d.st = ST_IDLE;
                end
            endcase
        end
        if (go) begin
            d.qctx = go_q;
            d.ptr = go_ptr;
            d.cur_qh = go_ptr[LNK_Q];
            if (go_ptr[LNK_T]) begin
                d.st = ST_DONE;
            end else begin
                d.st = ST_FETCH;
                d.mem.req = 1'b1;
                d.mem.we = 1'b0;
                d.mem.addr = uqs_link_addr(go_ptr) + QH_HLINK_OFS;
            end
        end
        if (hc_rst) begin
            d.run = 1'b0;
            d.cfg = 1'b0;
            d.susp = 1'b0;
            d.sts = '0;
            d.st = ST_IDLE;
            d.mem.req = 1'b0;
            d.exec_req = 1'b0;
            d.qctx = 1'b0;
            d.pend = 1'b0;
            cache_clr = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= ST_IDLE;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign mem_o = q.mem;
    assign exec_req_o = q.exec_req;
    assign exec_td_o = q.td_addr;
    assign walk_idle_o = (q.st == ST_IDLE) || (q.st == ST_DONE);
    assign run_o = q.run;
    assign halted_o = q.sts.halted;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    stop_halts_a: assert property (
        (!q.run && !hc_rst) |=> q.sts.halted)
        else $error("stopped controller not halted");

    pid_halt_a: assert property (
        (done_ev && res_bad && !hc_rst)
        |=> (!q.run && q.sts.proc_err && q.sts.halted && q.st == ST_IDLE))
        else $error("packet fault did not halt");

    abort_halt_a: assert property (
        (q.mem.req && mem_i.abort && !hc_rst)
        |=> (!q.run && q.sts.sys_err && q.sts.halted && !q.mem.req))
        else $error("bus abort did not halt");

    resume_flag_a: assert property (
        (resume_i && q.susp && !hc_rst) |=> q.sts.resume)
        else $error("resume in suspend not flagged");

    reset_clear_a: assert property (
        hc_rst |=> (q.sts == '0 && !q.run && !q.cfg && q.st == ST_IDLE))
        else $error("controller reset left flags set");

    ioc_flag_a: assert property (
        (done_ev && !res_bad && res_good && exec_res_i.status[TDS_IOC] && !hc_rst)
        |=> q.sts.done_irq)
        else $error("completion flag not set");

    stall_zero_a: assert property (
        (done_ev && !res_bad && res_err && res_cnt == 2'h1 && !hc_rst)
        |=> (q.st == ST_WBS && q.mem.we && !q.mem.wdata[TDS_ACT]
            && q.mem.wdata[TDS_STALL] && q.sts.err_irq))
        else $error("counted-out error not stalled");

    setup_to_a: assert property (
        (done_ev && !res_bad && exec_res_i.setup_hs && res_cnt == 2'h2 && !hc_rst)
        |=> (q.mem.wdata[TDS_CRCTO] && q.mem.wdata[TDS_CNT_LO +: 2] == 2'h1))
        else $error("setup handshake not a time-out");

    qe_write_a: assert property (
        (q.st == ST_WBQ && q.mem.req)
        |-> (q.mem.we && q.mem.addr == qh_a + QH_VLINK_OFS && q.mem.wdata == q.td_link))
        else $error("queue advance write wrong");

    no_adv_a: assert property (
        (q.st == ST_WBS && ackd && !mem_i.abort && !q.adv && !hc_rst)
        |=> (q.st != ST_WBQ && !q.qctx))
        else $error("queue advanced without success");

    empty_skip_a: assert property (
        (q.st == ST_QHV && ackd && !mem_i.abort && mem_i.rdata[LNK_T] && !hc_rst)
        |=> (q.ptr == $past(q.hlink) && q.st != ST_EXEC))
        else $error("empty queue not skipped");

    frame_clear_a: assert property (
        ((q.st == ST_IDLE || q.st == ST_DONE) && q.pend && q.run && !mem_i.abort)
        |=> (!qh_v && !q.qctx))
        else $error("queue context kept across frame");

endmodule

// *** src/uqs_wb_slave.sv ***
// Classic Wishbone slave for the command and status registers.
// Assumes the master holds a request until it samples ack.
`timescale 1ns/1ns
module uqs_wb_slave import uqs_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Register side
    input wire logic [31:0] cmd_rd_i,
    input wire logic [31:0] sts_rd_i,
    output uqs_regwr_type regwr_o
);

    uqs_wbs_type q;
    uqs_wbs_type d;
    logic hit;
    logic wr;

    always_comb begin
        d = q;
        hit = wb_cyc_i && wb_stb_i && !q.ack;
        d.ack = hit;
        if (hit && !wb_we_i) begin
            if (wb_adr_i == UQS_CMD_OFS) begin
                d.dat = cmd_rd_i;
            end else if (wb_adr_i == UQS_STS_OFS) begin
                d.dat = sts_rd_i;
            end else begin
                d.dat = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // Writes land on the edge where the master sees ack
    assign wr = q.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign regwr_o.wr_cmd = wr && (wb_adr_i == UQS_CMD_OFS);
    assign regwr_o.wr_sts = wr && (wb_adr_i == UQS_STS_OFS);
    assign regwr_o.wdata = wb_dat_i;
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;

endmodule

// *** tb/test_usb_host_queue_status_engine.sv ***
// Self-checking bench for the queue/status engine.
// Assumes uqs_far_model for memory and descriptor execution.
`timescale 1ns/1ns
module test_usb_host_queue_status_engine import uqs_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic fs = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd, rdo, xtd, st, want;
    logic [1:0] cnt;
    logic ack, idle, run, halt, xreq, xdone, interrupt_on_complete, vf;
    logic resm = 1'b0;
    logic abrt = 1'b0;
    uqs_mem_req_type mreq;
    uqs_mem_rsp_type mrsp;
    uqs_result_type res = '0;
    uqs_result_type r;
    int failures = 0;
    int comparisons = 0;
    always #4 clk_i = ~clk_i;
    uqs_queue_engine uqs_queue_engine_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack), .frame_start_i(fs),
        .frame_ptr_i(32'h0000_0012), .resume_i(resm), .mem_o(mreq), .mem_i(mrsp),
        .exec_req_o(xreq), .exec_td_o(xtd), .exec_done_i(xdone), .exec_res_i(res),
        .walk_idle_o(idle), .run_o(run), .halted_o(halt));
    uqs_far_model uqs_far_model_i (.clk_i(clk_i), .req_i(mreq), .exec_req_i(xreq),
        .abort_i(abrt), .rsp_o(mrsp), .done_o(xdone));
    task automatic conclude();
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_for(ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1) begin
            n++;
            if (n > 400) begin
                failures++;
                conclude();
            end
            @(posedge clk_i);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        wait_for(ack);
        rd = rdo;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic frame();
        fs <= 1'b1;
        @(posedge clk_i);
        fs <= 1'b0;
        repeat (3) @(posedge clk_i);
        wait_for(idle);
    endtask
    initial begin
        void'($urandom(68710));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0);
        check("unmapped", 32'h0, rd);
        wb(1'b1, UQS_CMD_OFS, 32'h0000_0041);
        wb(1'b0, UQS_CMD_OFS, 32'h0);
        check("command", 32'h0000_0041, rd);
        // Pass 0 completes and advances; pass 1 counts down on a SETUP NAK
        for (int k = 0; k < 2; k++) begin
            interrupt_on_complete = 1'($urandom % 2);
            vf = 1'($urandom % 2);
            cnt = 2'(($urandom % 3) + 1);
            st = 32'h0080_0000 | (32'(cnt) << 27) | (32'(interrupt_on_complete) << 24);
            uqs_far_model_i.mem[4] = 32'h0000_0001;
            uqs_far_model_i.mem[5] = 32'h0000_0020;
            uqs_far_model_i.mem[8] = 32'h0000_0041 | (32'(vf) << 2);
            uqs_far_model_i.mem[9] = st;
            r = '0;
            r.status = st;
            r.ok = (k == 0);
            r.setup_hs = (k == 1);
            res <= r;
            wb(1'b1, UQS_STS_OFS, 32'h0000_003F);
            frame();
            wb(1'b0, UQS_STS_OFS, 32'h0);
            if (k == 0) begin
                check("vlink", 32'h0000_0041 | (32'(vf) << 2),
                    uqs_far_model_i.mem[5]);
                check("td status", st & 32'hFF7F_FFFF, uqs_far_model_i.mem[9]);
                check("status", 32'(interrupt_on_complete), rd);
                check("exec td", 32'h0000_0020, xtd);
            end else begin
                want = (st & 32'hE7FF_FFFF) | (32'(cnt - 2'h1) << 27) | 32'h0004_0000;
                if (cnt == 2'h1) begin
                    want = (want & 32'hFF7F_FFFF) | 32'h0040_0000;
                end
                check("vlink", 32'h0000_0020, uqs_far_model_i.mem[5]);
                check("td status", want, uqs_far_model_i.mem[9]);
                check("status", (cnt == 2'h1) ? 32'h0000_0002 : 32'h0000_0000, rd);
            end
        end
        // Empty queue: nothing executed, nothing written back
        uqs_far_model_i.mem[5] = 32'h0000_0021;
        uqs_far_model_i.mem[9] = 32'h0000_0000;
        frame();
        check("empty queue", 32'h0, uqs_far_model_i.mem[9]);
        r = '0;
        r.pid_err = 1'b1;
        res <= r;
        uqs_far_model_i.mem[5] = 32'h0000_0020;
        wb(1'b1, UQS_STS_OFS, 32'h0000_003F);
        frame();
        wb(1'b0, UQS_STS_OFS, 32'h0);
        check("status", 32'h0000_0030, rd);
        check("run", 32'h0, 32'(run));
        wb(1'b1, UQS_CMD_OFS, 32'h0000_0002);
        wb(1'b0, UQS_CMD_OFS, 32'h0);
        check("command", 32'h0, rd);
        wb(1'b0, UQS_STS_OFS, 32'h0);
        check("status", 32'h0000_0020, rd);
        check("halted", 32'h1, 32'(halt));
        // Bus abort on the first fetch, then suspend and resume
        abrt <= 1'b1;
        wb(1'b1, UQS_CMD_OFS, 32'h0000_0001);
        frame();
        wb(1'b1, UQS_CMD_OFS, 32'h0000_0008);
        resm <= 1'b1;
        @(posedge clk_i);
        resm <= 1'b0;
        wb(1'b0, UQS_STS_OFS, 32'h0);
        check("status", 32'h0000_002C, rd);
        check("run", 32'h0, 32'(run));
        wb(1'b0, UQS_CMD_OFS, 32'h0);
        check("command", 32'h0000_0008, rd);
        conclude();
    end
endmodule

// *** tb/uqs_far_model.sv ***
// Memory and execution-unit model on the engine's far side.
// Assumes the bench preloads mem and sets the result before each frame.
`timescale 1ns/1ns
module uqs_far_model import uqs_pkg::*; (
    // Clock
    input wire logic clk_i,
    // Engine side
    input wire uqs_mem_req_type req_i,
    input wire logic exec_req_i,
    input wire logic abort_i,
    output uqs_mem_rsp_type rsp_o,
    output logic done_o
);
    logic [31:0] mem [0:15];
    logic coin = 1'b0;
    logic go;
    uqs_mem_rsp_type rsp_q = '0;
    logic done_q = 1'b0;
    // Random wait states, decided one edge ahead
    assign go = req_i.req && !rsp_q.ack && coin;
    assign rsp_o = rsp_q;
    assign done_o = done_q;
    always @(posedge clk_i) begin
        coin <= 1'($urandom % 2);
        rsp_q.ack <= go;
        // Abort rides on the answer while the bench asks for it
        rsp_q.abort <= go && abort_i;
        // word index from address bits, header word1 at +4
        rsp_q.rdata <= go ? mem[req_i.addr[5:2]] : ~rsp_q.rdata;
        if (go && req_i.we) begin
            mem[req_i.addr[5:2]] <= req_i.wdata;
        end
        // Random stall keeps the engine waiting on completion
        done_q <= exec_req_i && !done_q && ($urandom % 2 == 1);
    end
endmodule
